// ==== hdl/offset_trim_pkg.sv ====
package offset_trim_pkg;

   // ==========================================================
   // Register geometry
   // ==========================================================
   localparam int          NUM_TRIMS  = 7;   // Trim registers in the bank
   localparam int          REG_W      = 16;  // Stored register width
   localparam int          TRIM_W     = 12;  // Unsigned trim field width
   localparam int          IDX_W      = 3;   // Bank index width
   localparam int          APB_DW     = 32;  // APB data width
   localparam int          APB_AW     = 12;  // Least APB address width
   localparam int          INDEX_W    = 10;  // Width of a register index

   // Field layout of every trim register
   localparam int          TRIM_LSB   = 0;
   localparam int          TRIM_MSB   = 11;
   localparam int          RSV_LSB    = 12;
   localparam int          RSV_MSB    = 15;
   localparam logic [3:0]  RSV_VALUE  = 4'h0;

   // Reset value before the fuse content arrives
   localparam logic [15:0] TRIM_RESET = 16'h0000;

   // ==========================================================
   // Register indices (byte address is four times the index)
   // ==========================================================
   localparam logic [9:0]  CORE1_OFFSET_TRIM_IDX         = 10'h332;
   localparam logic [9:0]  CORE2_INPUT_A_OFFSET_TRIM_IDX = 10'h334;
   localparam logic [9:0]  CORE2_INPUT_B_OFFSET_TRIM_IDX = 10'h336;
   localparam logic [9:0]  CORE3_INPUT_C_OFFSET_TRIM_IDX = 10'h338;
   localparam logic [9:0]  CORE3_INPUT_D_OFFSET_TRIM_IDX = 10'h33a;
   localparam logic [9:0]  CORE4_OFFSET_TRIM_IDX         = 10'h33c;
   localparam logic [9:0]  CORE5_OFFSET_TRIM_IDX         = 10'h33e;

   // Position of each register in the bank, same order as above
   localparam logic [2:0]  SLOT_CORE1  = 3'h0;
   localparam logic [2:0]  SLOT_CORE2A = 3'h1;
   localparam logic [2:0]  SLOT_CORE2B = 3'h2;
   localparam logic [2:0]  SLOT_CORE3C = 3'h3;
   localparam logic [2:0]  SLOT_CORE3D = 3'h4;
   localparam logic [2:0]  SLOT_CORE4  = 3'h5;
   localparam logic [2:0]  SLOT_CORE5  = 3'h6;
   localparam logic [2:0]  SLOT_NONE   = 3'h7;  // Decode miss

   localparam logic [9:0]  TRIM_INDEX [NUM_TRIMS] = '{
      CORE1_OFFSET_TRIM_IDX, CORE2_INPUT_A_OFFSET_TRIM_IDX,
      CORE2_INPUT_B_OFFSET_TRIM_IDX, CORE3_INPUT_C_OFFSET_TRIM_IDX,
      CORE3_INPUT_D_OFFSET_TRIM_IDX, CORE4_OFFSET_TRIM_IDX,
      CORE5_OFFSET_TRIM_IDX};

   // ==========================================================
   // Fuse loader states
   // ==========================================================
   typedef enum logic [1:0] {
      FUSE_WAIT,
      FUSE_CAPTURE,
      FUSE_DONE
   } fuse_state_t;

endpackage

// ==== hdl/trim_fuse_loader.sv ====
`timescale 1ns/1ps

// Walks the fuse store once after reset and hands each trim word to the bank
module trim_fuse_loader #(
   parameter int NUM_WORDS = offset_trim_pkg::NUM_TRIMS,  // Words to fetch
   parameter int WORD_W    = offset_trim_pkg::TRIM_W      // Fused trim width
) (
   input  wire logic              clk_in,       // 100 MHz clock
   input  wire logic              arst_n_in,    // Async reset, low
   output logic                   fuse_rd_out,  // Fuse read strobe
   output logic [2:0]             fuse_idx_out, // Fuse word index
   input  wire logic [WORD_W-1:0] fuse_data_in, // Word, cycle after strobe
   output logic                   load_we_out,  // Write one trim word
   output logic [2:0]             load_idx_out, // Bank slot to write
   output logic [WORD_W-1:0]      load_data_out,// Fused trim value
   output logic                   done_out      // All words loaded
);

   localparam logic [2:0] LAST_IDX = 3'(NUM_WORDS - 1);

   // Index ports are three bits wide, so eight words at the most
   if (NUM_WORDS < 1 || NUM_WORDS > 8) begin : g_words_chk
      $error("fuse loader serves one to eight words");
   end

   offset_trim_pkg::fuse_state_t state_reg;
   logic [2:0]                   idx_reg;
   logic                         rd_reg;
   logic                         we_reg;
   logic [2:0]                   widx_reg;
   logic [WORD_W-1:0]            wdata_reg;
   logic                         done_reg;

   // ==========================================================
   // Fetch sequence: strobe, capture, repeat until last word
   // ==========================================================
   // Strobe is high out of reset so the first fetch costs no idle cycle
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg <= offset_trim_pkg::FUSE_WAIT;
         idx_reg   <= 3'h0;
         rd_reg    <= 1'b1;
         we_reg    <= 1'b0;
         widx_reg  <= 3'h0;
         wdata_reg <= '0;
         done_reg  <= 1'b0;
      end else begin
         we_reg <= 1'b0;
         case (state_reg)
            offset_trim_pkg::FUSE_WAIT: begin
               rd_reg    <= 1'b0;
               state_reg <= offset_trim_pkg::FUSE_CAPTURE;
            end
            offset_trim_pkg::FUSE_CAPTURE: begin
               we_reg    <= 1'b1;
               widx_reg  <= idx_reg;
               wdata_reg <= fuse_data_in;
               if (idx_reg == LAST_IDX) begin
                  state_reg <= offset_trim_pkg::FUSE_DONE;
               end else begin
                  idx_reg   <= idx_reg + 3'h1;
                  rd_reg    <= 1'b1;
                  state_reg <= offset_trim_pkg::FUSE_WAIT;
               end
            end
            offset_trim_pkg::FUSE_DONE: begin
               done_reg <= 1'b1;
            end
            default: begin
               state_reg <= offset_trim_pkg::FUSE_DONE;
            end
         endcase
      end
   end

   assign fuse_rd_out   = rd_reg;
   assign fuse_idx_out  = idx_reg;
   assign load_we_out   = we_reg;
   assign load_idx_out  = widx_reg;
   assign load_data_out = wdata_reg;
   assign done_out      = done_reg;

endmodule

// ==== hdl/offset_trim_regs.sv ====
`timescale 1ns/1ps

module offset_trim_regs #(
   parameter int APB_ADDR_W = offset_trim_pkg::APB_AW  // APB address width
) (
   input  wire logic                              clk_in,          // 100 MHz clock
   input  wire logic                              arst_n_in,       // Async reset, low
   // APB slave
   input  wire logic                              psel_in,         // Slave select
   input  wire logic                              penable_in,      // Access phase
   input  wire logic                              pwrite_in,       // Write when high
   input  wire logic [APB_ADDR_W-1:0]             paddr_in,        // Byte address
   input  wire logic [offset_trim_pkg::APB_DW-1:0] pwdata_in,      // Write data
   input  wire logic [3:0]                        pstrb_in,        // Byte enables
   output logic [offset_trim_pkg::APB_DW-1:0]     prdata_out,      // Read data
   output logic                                   pready_out,      // Transfer done
   output logic                                   pslverr_out,     // Transfer error
   // Fuse store
   output logic                                   fuse_rd_out,     // Fuse read strobe
   output logic [2:0]                             fuse_idx_out,    // Fuse word index
   input  wire logic [offset_trim_pkg::TRIM_W-1:0] fuse_data_in,   // Fused trim word
   output logic                                   trim_loaded_out, // Fuse load done
   // Calibration and input routing
   input  wire logic                              cal_offset_busy_in, // Offset cal running
   input  wire logic                              core2_sel_b_in,  // Core 2 on pair B
   input  wire logic                              core3_sel_d_in,  // Core 3 on pair D
   // Offset corrections to the converter cores
   output logic [offset_trim_pkg::TRIM_W-1:0]     core1_offset_out, // Core 1 correction
   output logic [offset_trim_pkg::TRIM_W-1:0]     core2_offset_out, // Core 2 correction
   output logic [offset_trim_pkg::TRIM_W-1:0]     core3_offset_out, // Core 3 correction
   output logic [offset_trim_pkg::TRIM_W-1:0]     core4_offset_out, // Core 4 correction
   output logic [offset_trim_pkg::TRIM_W-1:0]     core5_offset_out  // Core 5 correction
);

   localparam int TW = offset_trim_pkg::TRIM_W;
   localparam int RW = offset_trim_pkg::REG_W;

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   // Largest byte address, four times the last index, needs 12 bits
   if (APB_ADDR_W < offset_trim_pkg::APB_AW) begin : g_addr_chk
      $error("APB address too narrow for the trim bank");
   end

   // ==========================================================
   // Address decode
   // ==========================================================
   // Returns the bank slot for a byte address, or the miss code
   function automatic logic [2:0] slot_of(input logic [APB_ADDR_W-1:0] addr);
      logic [2:0] slot;
      slot = offset_trim_pkg::SLOT_NONE;
      for (int i = 0; i < offset_trim_pkg::NUM_TRIMS; i++) begin
         if ((addr[1:0] == 2'h0) &&
             (addr[APB_ADDR_W-1:2] == (APB_ADDR_W-2)'(offset_trim_pkg::TRIM_INDEX[i]))) begin
            slot = 3'(i);
         end
      end
      return slot;
   endfunction

   logic [RW-1:0]                         trim_reg [offset_trim_pkg::NUM_TRIMS];
   logic [offset_trim_pkg::APB_DW-1:0]    prdata_reg;
   logic                                  pready_reg;
   logic                                  pslverr_reg;
   logic [TW-1:0]                         core1_reg;
   logic [TW-1:0]                         core2_reg;
   logic [TW-1:0]                         core3_reg;
   logic [TW-1:0]                         core4_reg;
   logic [TW-1:0]                         core5_reg;

   logic                                  load_we;
   logic [2:0]                            load_idx;
   logic [TW-1:0]                         load_data;
   logic                                  load_done;

   wire logic [2:0]    hit_slot = slot_of(paddr_in);
   wire logic          hit      = (hit_slot != offset_trim_pkg::SLOT_NONE);
   wire logic          access   = psel_in & penable_in;
   // Answer only once the fuse content is in place
   wire logic          answer   = access & ~pready_reg & load_done;
   // Refuse unmapped addresses and any access during offset calibration
   wire logic          refuse   = ~hit | cal_offset_busy_in;
   // Write lands on the edge where the master sees pready high
   wire logic          wr_take  = access & pready_reg & pwrite_in & ~pslverr_reg;
   // Miss code lies past the bank, so a miss reads slot zero instead
   wire logic [2:0]    rd_slot  = hit ? hit_slot : offset_trim_pkg::SLOT_CORE1;
   wire logic [RW-1:0] cur_word = trim_reg[rd_slot];
   wire logic [RW-1:0] wr_word  = {pstrb_in[1] ? pwdata_in[15:8] : cur_word[15:8],
                                   pstrb_in[0] ? pwdata_in[7:0]  : cur_word[7:0]};
   wire logic [offset_trim_pkg::APB_DW-1:0] rd_word =
      refuse ? '0 : {{(offset_trim_pkg::APB_DW-RW){1'b0}}, cur_word};

   // ==========================================================
   // Fuse load after reset
   // ==========================================================
   trim_fuse_loader #(
      .NUM_WORDS (offset_trim_pkg::NUM_TRIMS),
      .WORD_W    (TW)
   ) u_fuse (
      .clk_in        (clk_in),
      .arst_n_in     (arst_n_in),
      .fuse_rd_out   (fuse_rd_out),
      .fuse_idx_out  (fuse_idx_out),
      .fuse_data_in  (fuse_data_in),
      .load_we_out   (load_we),
      .load_idx_out  (load_idx),
      .load_data_out (load_data),
      .done_out      (load_done)
   );

   // ==========================================================
   // Trim bank
   // ==========================================================
   // Fuse words land with reserved bits at their default; stored bits
   // 15:12 are kept as written so software reads back its own value
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         for (int i = 0; i < offset_trim_pkg::NUM_TRIMS; i++) begin
            trim_reg[i] <= offset_trim_pkg::TRIM_RESET;
         end
      end else begin
         for (int i = 0; i < offset_trim_pkg::NUM_TRIMS; i++) begin
            if (load_we && (load_idx == 3'(i))) begin
               trim_reg[i] <= {offset_trim_pkg::RSV_VALUE, load_data};
            end else if (wr_take && (hit_slot == 3'(i))) begin
               trim_reg[i] <= wr_word;
            end
         end
      end
   end

   // ==========================================================
   // APB answer: one wait cycle, then pready for one cycle
   // ==========================================================
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end else begin
         pready_reg  <= answer;
         pslverr_reg <= answer & refuse;
         prdata_reg  <= (answer & ~pwrite_in) ? rd_word : '0;
      end
   end

   // ==========================================================
   // Offset corrections, field taken as unsigned
   // ==========================================================
   // Input-pair selection picks which trim a shared core sees
   wire logic [TW-1:0] core2_pick = core2_sel_b_in ?
      trim_reg[offset_trim_pkg::SLOT_CORE2B][offset_trim_pkg::TRIM_MSB:0] :
      trim_reg[offset_trim_pkg::SLOT_CORE2A][offset_trim_pkg::TRIM_MSB:0];
   wire logic [TW-1:0] core3_pick = core3_sel_d_in ?
      trim_reg[offset_trim_pkg::SLOT_CORE3D][offset_trim_pkg::TRIM_MSB:0] :
      trim_reg[offset_trim_pkg::SLOT_CORE3C][offset_trim_pkg::TRIM_MSB:0];

   // Registered so the cores see a glitch-free word; costs one cycle
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         core1_reg <= '0;
         core2_reg <= '0;
         core3_reg <= '0;
         core4_reg <= '0;
         core5_reg <= '0;
      end else begin
         core1_reg <= trim_reg[offset_trim_pkg::SLOT_CORE1][offset_trim_pkg::TRIM_MSB:0];
         core2_reg <= core2_pick;
         core3_reg <= core3_pick;
         core4_reg <= trim_reg[offset_trim_pkg::SLOT_CORE4][offset_trim_pkg::TRIM_MSB:0];
         core5_reg <= trim_reg[offset_trim_pkg::SLOT_CORE5][offset_trim_pkg::TRIM_MSB:0];
      end
   end

   // Plain zero-extended fields, no sign handling anywhere
   assign core1_offset_out = core1_reg;
   assign core2_offset_out = core2_reg;
   assign core3_offset_out = core3_reg;
   assign core4_offset_out = core4_reg;
   assign core5_offset_out = core5_reg;
   assign prdata_out       = prdata_reg;
   assign pready_out       = pready_reg;
   assign pslverr_out      = pslverr_reg;
   assign trim_loaded_out  = load_done;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   sequence apb_setup_s;
      psel_in && !penable_in;
   endsequence

   sequence apb_wait_s;
      psel_in && penable_in && !pready_out;
   endsequence

   core1_trim_a: assert property (
      ##1 core1_offset_out == $past(trim_reg[offset_trim_pkg::SLOT_CORE1][11:0]))
      else $error("core 1 correction does not follow its trim");

   core2_pair_a_a: assert property (
      !core2_sel_b_in |=> core2_offset_out ==
         $past(trim_reg[offset_trim_pkg::SLOT_CORE2A][11:0]))
      else $error("core 2 pair A correction wrong");

   core2_pair_b_a: assert property (
      core2_sel_b_in |=> core2_offset_out ==
         $past(trim_reg[offset_trim_pkg::SLOT_CORE2B][11:0]))
      else $error("core 2 pair B correction wrong");

   core3_pair_c_a: assert property (
      !core3_sel_d_in |=> core3_offset_out ==
         $past(trim_reg[offset_trim_pkg::SLOT_CORE3C][11:0]))
      else $error("core 3 pair C correction wrong");

   core3_pair_d_a: assert property (
      core3_sel_d_in |=> core3_offset_out ==
         $past(trim_reg[offset_trim_pkg::SLOT_CORE3D][11:0]))
      else $error("core 3 pair D correction wrong");

   core4_trim_a: assert property (
      $changed(trim_reg[offset_trim_pkg::SLOT_CORE4]) |=>
         core4_offset_out == $past(trim_reg[offset_trim_pkg::SLOT_CORE4][11:0]))
      else $error("core 4 correction does not follow its trim");

   core5_trim_a: assert property (
      ##1 core5_offset_out == $past(trim_reg[offset_trim_pkg::SLOT_CORE5][11:0]))
      else $error("core 5 correction does not follow its trim");

   fuse_load_a: assert property (
      load_we && load_idx == offset_trim_pkg::SLOT_CORE1 |=>
         trim_reg[offset_trim_pkg::SLOT_CORE1] == {offset_trim_pkg::RSV_VALUE, $past(load_data)})
      else $error("fused trim not loaded into register");

   unsigned_field_a: assert property (
      pready_out && !pslverr_out |->
         prdata_out[offset_trim_pkg::APB_DW-1:offset_trim_pkg::RSV_LSB] == '0)
      else $error("sign bits leak into read data");

   cal_refuse_a: assert property (
      apb_wait_s ##0 (cal_offset_busy_in && load_done) |=> pready_out && pslverr_out)
      else $error("access during offset calibration not refused");

   apb_answer_a: assert property (
      apb_setup_s ##1 apb_wait_s ##0 load_done |=> pready_out ##1 !pready_out)
      else $error("APB answer not one wait cycle and one pready cycle");

   // Each fused word lands in the slot that the loader names
   fuse_load_any_a: assert property (
      load_we |=>
         trim_reg[$past(load_idx)] == {offset_trim_pkg::RSV_VALUE, $past(load_data)})
      else $error("fused trim landed in the wrong slot");

   // Fuse load flag, once set, stays until the next reset
   loaded_stays_a: assert property (
      load_done |=> load_done)
      else $error("fuse load flag dropped without reset");

   // No answer while the fuse load still runs
   load_stall_a: assert property (
      !load_done |=> !pready_out)
      else $error("APB answered before the fuse load ended");

   // A refused write leaves the core 1 and core 2 pair A trims untouched
   refused_write_a: assert property (
      pready_out && pslverr_out |=>
         $stable(trim_reg[offset_trim_pkg::SLOT_CORE1]) &&
         $stable(trim_reg[offset_trim_pkg::SLOT_CORE2A]))
      else $error("refused write changed a trim register");

   // A refused read returns zero
   refused_read_a: assert property (
      pready_out && pslverr_out |-> prdata_out == '0)
      else $error("refused read returned data");

   // Read data and error stand only in the pready cycle
   rdata_idle_a: assert property (
      !pready_out |-> prdata_out == '0 && !pslverr_out)
      else $error("read data or error outside the pready cycle");

   // Pready is a one-cycle pulse
   ready_pulse_a: assert property (
      pready_out |=> !pready_out)
      else $error("pready held for more than one cycle");

   // A full-word write lands on the edge where pready is seen high
   write_lands_a: assert property (
      psel_in && penable_in && pwrite_in && pready_out && !pslverr_out &&
      pstrb_in == 4'h3 |=> trim_reg[$past(hit_slot)] == $past(pwdata_in[RW-1:0]))
      else $error("accepted write did not land in its register");

endmodule

// ==== test/converter_offset_trim_registers_bench.sv ====
`timescale 1ns/1ps

module converter_offset_trim_registers_bench;
   // ==========================================================
   // Signals
   // ==========================================================
   logic        clk_in;
   logic        arst_n_in;
   logic        psel_in;
   logic        penable_in;
   logic        pwrite_in;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in;
   logic [3:0]  pstrb_in;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        fuse_rd_out;
   logic [2:0]  fuse_idx_out;
   logic [11:0] fuse_data_in;
   logic        trim_loaded_out;
   logic        cal_offset_busy_in;
   logic        core2_sel_b_in;
   logic        core3_sel_d_in;
   logic [11:0] core1_offset_out;
   logic [11:0] core2_offset_out;
   logic [11:0] core3_offset_out;
   logic [11:0] core4_offset_out;
   logic [11:0] core5_offset_out;
   logic [15:0] mdl [7];       // Expected register contents
   logic [11:0] fuse_tab [7];  // Fused trim words
   logic [33:0] exp_q [$];     // Notes of {is_read, err, data}
   logic [33:0] e;
   int          error_cnt;
   int          total_checks;
   int          cyc;

   offset_trim_regs dut (
      .clk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
      .fuse_rd_out, .fuse_idx_out, .fuse_data_in, .trim_loaded_out,
      .cal_offset_busy_in, .core2_sel_b_in, .core3_sel_d_in,
      .core1_offset_out, .core2_offset_out, .core3_offset_out,
      .core4_offset_out, .core5_offset_out
   );

   // ==========================================================
   // Clock, verdict and compares
   // ==========================================================
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic end_sim();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp_data(input string nm, input logic [31:0] x, input logic [31:0] g);
      total_checks++;
      if (g !== x) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic cmp_trim(input string nm, input logic [11:0] x, input logic [11:0] g);
      cmp_data(nm, {20'h0_0000, x}, {20'h0_0000, g});
   endtask

   task automatic cmp_flag(input string nm, input logic x, input logic g);
      cmp_data(nm, {31'h0000_0000, x}, {31'h0000_0000, g});
   endtask

   // Fuse store answers the cycle after a strobe, then scrambles the line
   always @(posedge clk_in) begin
      if (fuse_rd_out === 1'b1) begin
         fuse_data_in <= fuse_tab[fuse_idx_out];
      end else begin
         fuse_data_in <= ~fuse_data_in;
      end
   end

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         end_sim();
      end
   end

   // Oldest note is matched against each completed transfer
   always @(posedge clk_in) begin
      if (pready_out === 1'b1) begin
         if (exp_q.size() == 0) begin
            cmp_flag("stray pready", 1'b0, 1'b1);
         end else begin
            e = exp_q.pop_front();
            cmp_flag("pslverr", e[32], pslverr_out);
            if (e[33]) begin
               cmp_data("prdata", e[31:0], prdata_out);
            end
         end
      end
   end

   // ==========================================================
   // APB master and register helpers
   // ==========================================================
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [1:0] lo,
                      input logic [31:0] wd, input logic [3:0] st, input logic [31:0] rd,
                      input logic err);
      int n;
      exp_q.push_back({~wr, err, rd});
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= {idx, lo};
      pwdata_in <= wd;
      pstrb_in <= st;
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 100);
      if (pready_out !== 1'b1) begin
         cmp_flag("pready", 1'b1, pready_out);
      end
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic wr_reg(input int s, input logic [15:0] v, input logic [3:0] st,
                         input logic err);
      apb(1'b1, offset_trim_pkg::TRIM_INDEX[s], 2'b00, {16'h0000, v}, st, 32'h0000_0000, err);
      if (!err && st[0]) mdl[s][7:0] = v[7:0];
      if (!err && st[1]) mdl[s][15:8] = v[15:8];
   endtask

   task automatic rd_reg(input int s, input logic err);
      apb(1'b0, offset_trim_pkg::TRIM_INDEX[s], 2'b00, 32'h0000_0000, 4'h0,
          err ? 32'h0000_0000 : {16'h0000, mdl[s]}, err);
   endtask

   task automatic rd_all();
      for (int s = 0; s < 7; s++) begin
         rd_reg(s, 1'b0);
      end
   endtask

   // Outputs lag the register or the input selection by one edge
   task automatic chk_cores();
      repeat (2) @(posedge clk_in);
      cmp_trim("core1", mdl[0][11:0], core1_offset_out);
      cmp_trim("core2", core2_sel_b_in ? mdl[2][11:0] : mdl[1][11:0], core2_offset_out);
      cmp_trim("core3", core3_sel_d_in ? mdl[4][11:0] : mdl[3][11:0], core3_offset_out);
      cmp_trim("core4", mdl[5][11:0], core4_offset_out);
      cmp_trim("core5", mdl[6][11:0], core5_offset_out);
   endtask

   // New fuse words each time, so a stale bank shows up after reset
   task automatic do_reset();
      for (int i = 0; i < 7; i++) begin
         fuse_tab[i] = 12'($urandom);
         mdl[i] = {4'h0, fuse_tab[i]};
      end
      arst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      cmp_trim("core1 in reset", 12'h000, core1_offset_out);
      arst_n_in <= 1'b1;
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      void'($urandom(99));
      {psel_in, penable_in, pwrite_in, cal_offset_busy_in} = 4'h0;
      {core2_sel_b_in, core3_sel_d_in, arst_n_in} = 3'h0;
      paddr_in = 12'h000;
      pwdata_in = 32'h0000_0000;
      pstrb_in = 4'h0;
      fuse_data_in = 12'h000;
      error_cnt = 0;
      total_checks = 0;
      cyc = 0;
      @(posedge clk_in);
      do_reset();
      rd_reg(0, 1'b0);
      cmp_flag("trim_loaded", 1'b1, trim_loaded_out);
      rd_all();
      chk_cores();
      // Random trims with reserved bits kept clear, then input swaps
      for (int r = 0; r < 4; r++) begin
         for (int s = 0; s < 7; s++) begin
            wr_reg(s, {4'h0, 12'($urandom)}, 4'h3, 1'b0);
         end
         rd_all();
         for (int k = 0; k < 4; k++) begin
            core2_sel_b_in <= 1'($urandom);
            core3_sel_d_in <= 1'($urandom);
            chk_cores();
         end
      end
      // Field extremes, a low-byte-only and a high-byte-only write
      wr_reg(6, 16'h0fff, 4'h3, 1'b0);
      wr_reg(5, 16'h0000, 4'h3, 1'b0);
      wr_reg(0, 16'h0abc, 4'h1, 1'b0);
      wr_reg(3, 16'h05a5, 4'h2, 1'b0);
      rd_reg(0, 1'b0);
      rd_reg(3, 1'b0);
      chk_cores();
      // Unmapped, neighbouring and misaligned accesses are refused
      apb(1'b0, 10'h330, 2'b00, 32'h0000_0000, 4'h0, 32'h0000_0000, 1'b1);
      apb(1'b1, 10'h340, 2'b00, 32'h0000_0555, 4'h3, 32'h0000_0000, 1'b1);
      apb(1'b0, offset_trim_pkg::CORE1_OFFSET_TRIM_IDX, 2'b10, 32'h0000_0000, 4'h0,
          32'h0000_0000, 1'b1);
      apb(1'b1, offset_trim_pkg::CORE1_OFFSET_TRIM_IDX, 2'b01, 32'h0000_0fff, 4'h3,
          32'h0000_0000, 1'b1);
      // Accesses while offset calibration runs are refused
      cal_offset_busy_in <= 1'b1;
      wr_reg(1, 16'h0123, 4'h3, 1'b1);
      rd_reg(1, 1'b1);
      cal_offset_busy_in <= 1'b0;
      rd_all();
      chk_cores();
      // Reset in mid-run reloads the bank from the fuse store
      do_reset();
      rd_all();
      chk_cores();
      end_sim();
   end
endmodule
